/* File: hdl/bws_pkg.sv */
// Constants for the low half of the built-in test status word.
// Assumes a 16-bit host register port and a 250 MHz reference clock.
package bws_pkg;
  localparam int          BWS_WORD_W       = 16;
  localparam int          BWS_ADDR_W       = 6;
  // Field positions inside the test status word
  localparam int          BWS_USER_HI      = 11;
  localparam int          BWS_USER_LO      = 6;
  localparam int          BWS_LBF_A_BIT    = 5;
  localparam int          BWS_LBF_B_BIT    = 4;
  localparam int          BWS_RAM_BIT      = 3;
  localparam int          BWS_PAR_BIT      = 2;
  localparam int          BWS_EEL_BIT      = 1;
  localparam int          BWS_TFI_BIT      = 0;
  // Reset values
  localparam logic [5:0]  BWS_USER_RST     = 6'h00;
  localparam logic [15:0] BWS_WORD_RST     = 16'h0000;
  localparam logic [5:0]  BWS_ADDR_RST     = 6'h00;
  // Reply from the word mux lands this many cycles after the request
  localparam int          BWS_REPLY_DELAY  = 1;

  // Odd parity over the six terminal address bits is the healthy state
  function automatic logic bws_parity_bad(input logic [5:0] a);
    bws_parity_bad = ~(^a);
  endfunction
endpackage

/* File: hdl/bws_addr_parity.sv */
// Terminal address copy of the operational status bits and its parity flag.
// Assumes pins are stable at reset release and EEPROM data comes as a pulse.
`timescale 1ns/1ps
module bws_addr_parity
  import bws_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Address sources
  input  wire logic [BWS_ADDR_W-1:0] addr_pins,
  input  wire logic                  eeprom_addr_valid,
  input  wire logic [BWS_ADDR_W-1:0] eeprom_addr,
  // Results
  output logic      [BWS_ADDR_W-1:0] term_addr,
  output logic                       parity_fail
);
  logic loaded;

  // Pins are caught on the first edge after release, never by the reset itself
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loaded    <= 1'b0;
      term_addr <= BWS_ADDR_RST;
    end
    else if (!loaded)
    begin
      loaded    <= 1'b1;
      term_addr <= addr_pins;
    end
    else if (eeprom_addr_valid && eeprom_addr != term_addr)
    begin
      term_addr <= eeprom_addr;
    end
  end

  // Flag follows the held address one cycle later, so it re-evaluates on reload
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      parity_fail <= 1'b0;
    else
      parity_fail <= loaded & bws_parity_bad(term_addr);
  end

  a_parity_follow : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(loaded) |-> parity_fail == bws_parity_bad($past(term_addr)))
    else $error("parity flag does not follow address");
  a_eeprom_reload : assert property (@(posedge ref_clk) disable iff (!rst_n)
    loaded && eeprom_addr_valid |=> term_addr == $past(eeprom_addr))
    else $error("eeprom address not loaded");
endmodule

/* File: hdl/bws_status_word.sv */
// Low half (bits 11:0) of the built-in test status word of a remote terminal.
// Assumes all event inputs are one-cycle pulses synchronous to ref_clk and that
// rst_n is the master reset pin; software reset arrives as a pulse.
//
// Behaviour
// - Bits 11..6 are a free host read/write field, zero after master reset.
// - Bit 5 sets on bus A loopback failure; cleared by master or software reset.
// - Bit 4 sets on bus B loopback failure; cleared by master or software reset.
// - Bit 3 shows RAM self-test failure, including the automatic post-reset test.
// - Bit 2 is high while the six terminal address bits fail parity.
// - Address bits load from pins after reset, then from differing EEPROM data.
// - Bit 1 sets only if auto-init enable is high and EEPROM copy fails.
// - On an EEPROM failure with auto-init enabled, also flag which failure kind on the opstat_fail_kind output.
// - Bit 0 sets when inhibit-terminal-flag mode code disables the flag.
// - Bit 0 clears when the override-inhibit mode code cancels that.
// - Transmit-test-word mode code sends this word unless alternate word chosen.
`timescale 1ns/1ps
module bws_status_word
  import bws_pkg::*;
(
  // Clock and master reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  software_reset,
  // Host register port
  input  wire logic                  reg_wr,
  input  wire logic [BWS_WORD_W-1:0] reg_wdata,
  output logic      [BWS_WORD_W-1:0] reg_rdata,
  // Self-test results
  input  wire logic                  loopback_fail_a,
  input  wire logic                  loopback_fail_b,
  input  wire logic                  ram_test_done,
  input  wire logic                  ram_selftest_fail,
  // Terminal address sources
  input  wire logic [BWS_ADDR_W-1:0] addr_pins,
  input  wire logic                  eeprom_addr_valid,
  input  wire logic [BWS_ADDR_W-1:0] eeprom_addr,
  output logic      [BWS_ADDR_W-1:0] term_addr,
  // EEPROM auto-initialisation
  input  wire logic                  auto_init_enable_pin,
  input  wire logic                  eeprom_done,
  input  wire logic                  eeprom_fail,
  input  wire logic                  eeprom_fail_kind,
  output logic      [1:0]            opstat_fail_kind,
  // Terminal flag mode codes
  input  wire logic                  inhibit_flag_done,
  input  wire logic                  override_flag_done,
  // Transmit test word mode code
  input  wire logic                  test_word_req,
  input  wire logic                  alternate_test_word_select,
  output logic                       resp_valid,
  output logic      [BWS_WORD_W-1:0] resp_word,
  output logic                       buf_wr,
  output logic      [BWS_WORD_W-1:0] buf_data
);
  logic [5:0] user_field;
  logic       loopback_a_flag;
  logic       loopback_b_flag;
  logic       ram_flag;
  logic       parity_flag;
  logic       eeprom_load_fail;
  logic       terminal_flag_inhibited;
  logic [BWS_WORD_W-1:0] word;

  // Address copy and parity live in their own leaf
  bws_addr_parity u_addr (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .addr_pins         (addr_pins),
    .eeprom_addr_valid (eeprom_addr_valid),
    .eeprom_addr       (eeprom_addr),
    .term_addr         (term_addr),
    .parity_fail       (parity_flag)
  );

  // Assembled word; bits 15:12 belong to the shutdown logic and read zero here
  always_comb
  begin
    word                                = BWS_WORD_RST;
    word[BWS_USER_HI:BWS_USER_LO]       = user_field;
    word[BWS_LBF_A_BIT]                 = loopback_a_flag;
    word[BWS_LBF_B_BIT]                 = loopback_b_flag;
    word[BWS_RAM_BIT]                   = ram_flag;
    word[BWS_PAR_BIT]                   = parity_flag;
    word[BWS_EEL_BIT]                   = eeprom_load_fail;
    word[BWS_TFI_BIT]                   = terminal_flag_inhibited;
  end

  // User field: software reset leaves it alone, only master reset clears it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      user_field <= BWS_USER_RST;
    else if (reg_wr)
      user_field <= reg_wdata[BWS_USER_HI:BWS_USER_LO];
  end

  // Loopback flags; a failure in the software reset cycle wins so it is not lost.
  // Host writes to these bits are dropped on purpose.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopback_a_flag <= 1'b0;
      loopback_b_flag <= 1'b0;
    end
    else
    begin
      loopback_a_flag <= loopback_fail_a | (loopback_a_flag & ~software_reset);
      loopback_b_flag <= loopback_fail_b | (loopback_b_flag & ~software_reset);
    end
  end

  // RAM test result; each completed test, the post-reset one first, rewrites it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ram_flag <= 1'b0;
    else if (ram_test_done)
      ram_flag <= ram_selftest_fail;
  end

  // EEPROM load failure, meaningful only with auto-init enabled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eeprom_load_fail <= 1'b0;
      opstat_fail_kind <= 2'h0;
    end
    else if (eeprom_done && eeprom_fail && auto_init_enable_pin)
    begin
      eeprom_load_fail <= 1'b1;
      opstat_fail_kind <= eeprom_fail_kind ? 2'h2 : 2'h1;
    end
  end

  // Terminal flag inhibit; inhibit in the same cycle as an override or software reset wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      terminal_flag_inhibited <= 1'b0;
    else if (inhibit_flag_done)
      terminal_flag_inhibited <= 1'b1;
    else if (override_flag_done || software_reset)
      terminal_flag_inhibited <= 1'b0;
  end

  // Read data is registered so the host sees a clean flop output
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= BWS_WORD_RST;
    else
      reg_rdata <= word;
  end

  // Mode code reply and buffer copy; the alternate word is served elsewhere
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp_word  <= BWS_WORD_RST;
      buf_wr     <= 1'b0;
      buf_data   <= BWS_WORD_RST;
    end
    else
    begin
      resp_valid <= test_word_req & ~alternate_test_word_select;
      buf_wr     <= test_word_req & ~alternate_test_word_select;
      if (test_word_req && !alternate_test_word_select)
      begin
        resp_word <= word;
        buf_data  <= word;
      end
    end
  end

  // User field and read path: writes land, nothing else moves the field
  a_user_write : assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr |=> user_field == $past(reg_wdata[BWS_USER_HI:BWS_USER_LO]))
    else $error("user field write lost");
  a_user_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_wr |=> $stable(user_field))
    else $error("user field moved without a write");
  a_user_reset : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |-> reg_rdata[BWS_USER_HI:BWS_USER_LO] == BWS_USER_RST)
    else $error("user field not cleared by master reset");
  a_rdata_track : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> reg_rdata == $past(word))
    else $error("read data does not follow the word");

  // Loopback flags: set by a failure pulse, shown two edges on, cleared by soft reset
  a_lbf_a_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
    loopback_fail_a |=> ##1 reg_rdata[BWS_LBF_A_BIT])
    else $error("loopback A flag not shown");
  a_lbf_a_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
    software_reset && !loopback_fail_a |=> !loopback_a_flag)
    else $error("loopback A flag survives software reset");
  a_lbf_a_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    loopback_a_flag && !software_reset |=> loopback_a_flag)
    else $error("loopback A flag lost");
  a_lbf_b_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
    loopback_fail_b |=> ##1 reg_rdata[BWS_LBF_B_BIT])
    else $error("loopback B flag not shown");
  a_lbf_b_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
    software_reset && !loopback_fail_b |=> !loopback_b_flag)
    else $error("loopback B flag survives software reset");
  a_lbf_b_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    loopback_b_flag && !software_reset |=> loopback_b_flag)
    else $error("loopback B flag lost");

  // RAM result: only a completed test rewrites it
  a_ram_result : assert property (@(posedge ref_clk) disable iff (!rst_n)
    ram_test_done |=> ram_flag == $past(ram_selftest_fail))
    else $error("RAM result not captured");
  a_ram_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ram_test_done |=> $stable(ram_flag))
    else $error("RAM result moved without a test");
  a_ram_shown : assert property (@(posedge ref_clk) disable iff (!rst_n)
    ram_test_done |=> ##1 reg_rdata[BWS_RAM_BIT] == $past(ram_selftest_fail, 2))
    else $error("RAM result not shown");

  // Address copy: pins caught after reset, parity flag passed on to the word
  a_par_shown : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> reg_rdata[BWS_PAR_BIT] == $past(parity_flag))
    else $error("parity flag not shown");
  a_addr_pins : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |=> term_addr == $past(addr_pins))
    else $error("address not taken from pins");

  // Load failure: gated by the enable pin, sticky, tagged with its kind
  a_eel_gate : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(eeprom_load_fail) |-> $past(auto_init_enable_pin && eeprom_fail))
    else $error("EEPROM flag set without enable");
  a_eel_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
    eeprom_done && eeprom_fail && auto_init_enable_pin |=> eeprom_load_fail)
    else $error("EEPROM failure not flagged");
  a_eel_sticky : assert property (@(posedge ref_clk) disable iff (!rst_n)
    eeprom_load_fail |=> eeprom_load_fail)
    else $error("EEPROM flag lost");
  a_kind_with_fail : assert property (@(posedge ref_clk) disable iff (!rst_n)
    eeprom_load_fail |-> opstat_fail_kind != 2'h0)
    else $error("failure kind missing");
  a_kind_code : assert property (@(posedge ref_clk) disable iff (!rst_n)
    eeprom_done && eeprom_fail && auto_init_enable_pin |=>
      opstat_fail_kind == {$past(eeprom_fail_kind), ~$past(eeprom_fail_kind)})
    else $error("failure kind code wrong");
  a_kind_idle : assert property (@(posedge ref_clk) disable iff (!rst_n)
    !eeprom_load_fail |-> opstat_fail_kind == 2'h0)
    else $error("failure kind shown without failure");

  // Terminal flag inhibit: set beats clear; override and soft reset clear it
  a_tfi_set : assert property (@(posedge ref_clk) disable iff (!rst_n)
    inhibit_flag_done |=> terminal_flag_inhibited)
    else $error("inhibit flag not set");
  a_tfi_shown : assert property (@(posedge ref_clk) disable iff (!rst_n)
    inhibit_flag_done |=> ##1 reg_rdata[BWS_TFI_BIT])
    else $error("inhibit flag not shown");
  a_tfi_soft : assert property (@(posedge ref_clk) disable iff (!rst_n)
    software_reset && !inhibit_flag_done |=> !terminal_flag_inhibited)
    else $error("inhibit flag survives software reset");
  a_tfi_clear : assert property (@(posedge ref_clk) disable iff (!rst_n)
    override_flag_done && !inhibit_flag_done |=> !terminal_flag_inhibited)
    else $error("inhibit flag not cleared");
  a_tfi_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
    terminal_flag_inhibited && !override_flag_done && !software_reset |=> terminal_flag_inhibited)
    else $error("inhibit flag lost");

  // Test word reply: one pulse per served request, none while the alternate is chosen
  a_reply_word : assert property (@(posedge ref_clk) disable iff (!rst_n)
    test_word_req && !alternate_test_word_select |=> resp_valid && buf_wr
      && resp_word == $past(word) && buf_data == $past(word))
    else $error("test word reply wrong");
  a_reply_quiet : assert property (@(posedge ref_clk) disable iff (!rst_n)
    alternate_test_word_select || !test_word_req |=> !resp_valid && !buf_wr)
    else $error("reply without a served request");

  // Host writes leave the loopback, load failure and inhibit flags alone
  a_ro_bits : assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !loopback_fail_a && !software_reset |=> loopback_a_flag == $past(loopback_a_flag))
    else $error("host write moved a flag");
  a_ro_bits_b : assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !loopback_fail_b && !software_reset |=> $stable(loopback_b_flag))
    else $error("host write moved loopback B flag");
  a_ro_eel : assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !eeprom_done |=> $stable(eeprom_load_fail))
    else $error("host write moved load failure flag");
  a_ro_tfi : assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !inhibit_flag_done && !override_flag_done && !software_reset
      |=> $stable(terminal_flag_inhibited))
    else $error("host write moved inhibit flag");

  // Main scenarios worth seeing at least once
  c_reply : cover property (@(posedge ref_clk) disable iff (!rst_n)
    resp_valid);
  c_tfi_cycle : cover property (@(posedge ref_clk) disable iff (!rst_n)
    inhibit_flag_done ##[1:20] override_flag_done);
  c_eel : cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(eeprom_load_fail));
  c_soft_clear : cover property (@(posedge ref_clk) disable iff (!rst_n)
    software_reset && terminal_flag_inhibited);
  c_alt_quiet : cover property (@(posedge ref_clk) disable iff (!rst_n)
    test_word_req && alternate_test_word_select);
endmodule

/* File: tb/bws_host_model.sv */
// Host processor model on the plain strobe register port of the status word.
// Assumes the caller is just past a clock edge when a task is entered.
`timescale 1ns/1ps
module bws_host_model
  import bws_pkg::*;
(
  // Clock
  input  wire logic                  ref_clk,
  // Register port
  input  wire logic [BWS_WORD_W-1:0] reg_rdata,
  output logic      [BWS_WORD_W-1:0] reg_wdata,
  output logic                       reg_wr
);
  // Idle bus with no strobe
  initial
  begin
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One-cycle write strobe; released data is scrambled so stale values never match
  task automatic wr(input logic [BWS_WORD_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the low half of the built-in test status word.
// Assumes the host model owns the register port; events are one-cycle pulses.
`timescale 1ns/1ps
module tb;
  logic        ref_clk, rst_n, ram_selftest_fail, eeprom_fail, eeprom_fail_kind;
  logic        auto_init_enable_pin, alternate_test_word_select, reg_wr, resp_valid, buf_wr;
  logic [8:0]  ev;
  logic [5:0]  addr_pins, eeprom_addr, term_addr, u, f, a;
  logic [1:0]  opstat_fail_kind;
  logic [15:0] reg_wdata, reg_rdata, resp_word, buf_data, d;
  int          err_count, samples_checked, seed;

  // Event strobes share one vector so a pulse task can drive any mix
  bws_status_word dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .software_reset(ev[8]),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .loopback_fail_a(ev[0]), .loopback_fail_b(ev[1]), .ram_test_done(ev[2]),
    .ram_selftest_fail(ram_selftest_fail), .addr_pins(addr_pins),
    .eeprom_addr_valid(ev[3]), .eeprom_addr(eeprom_addr), .term_addr(term_addr),
    .auto_init_enable_pin(auto_init_enable_pin), .eeprom_done(ev[4]),
    .eeprom_fail(eeprom_fail), .eeprom_fail_kind(eeprom_fail_kind),
    .opstat_fail_kind(opstat_fail_kind), .inhibit_flag_done(ev[5]),
    .override_flag_done(ev[6]), .test_word_req(ev[7]),
    .alternate_test_word_select(alternate_test_word_select), .resp_valid(resp_valid),
    .resp_word(resp_word), .buf_wr(buf_wr), .buf_data(buf_data));

  bws_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr));

  // Clock at 250 MHz
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] exp_word(input logic [5:0] uf, input logic [5:0] fl);
    return {4'h0, uf, fl};
  endfunction

  // Odd parity over the address is healthy
  function automatic logic par_bad(input logic [5:0] x);
    return ~(^x);
  endfunction

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_small(input logic [5:0] g, input logic [5:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t field got %h exp %h", $time, g, e);
    end
  endtask

  task automatic look(input string s);
    chk_word(reg_rdata, exp_word(u, f));
    $display("test %s done", s);
  endtask

  // Pulse, then wait until the register output has settled
  task automatic fire(input logic [8:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 9'h000;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Reply pulses are one cycle wide, so they are sampled in that cycle
  task automatic tw(input logic alt);
    @(posedge ref_clk);
    alternate_test_word_select <= alt;
    ev <= 9'h080;
    @(posedge ref_clk);
    ev <= 9'h000;
    #1;
    chk_small({4'h0, resp_valid, buf_wr}, {4'h0, ~alt, ~alt});
    if (!alt)
    begin
      chk_word(resp_word, exp_word(u, f));
      chk_word(buf_data, exp_word(u, f));
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the hundred or so cycles the tests need
  initial
  begin
    #20000;
    err_count++;
    print_verdict;
  end

  initial
  begin
    seed = 47221;
    {ev, ram_selftest_fail, eeprom_fail, eeprom_fail_kind} = '0;
    {auto_init_enable_pin, alternate_test_word_select, eeprom_addr, u, f} = '0;
    addr_pins = 6'h01;
    rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_small(term_addr, 6'h01);
    look("reset");
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 16'hffff : $random(seed);
      host_u.wr(d);
      u = d[11:6];
      look("user");
    end
    ram_selftest_fail <= 1'b1;
    fire(9'h027);
    f = 6'b111001;
    look("events");
    tw(1'b0);
    tw(1'b0);
    tw(1'b1);
    host_u.wr(16'h0000);
    u = 6'h00;
    look("ro write");
    fire(9'h100);
    f = 6'b001000;
    look("soft reset");
    fire(9'h020);
    f[0] = 1'b1;
    look("inhibit");
    fire(9'h040);
    f[0] = 1'b0;
    look("override");
    ram_selftest_fail <= 1'b0;
    fire(9'h004);
    f[3] = 1'b0;
    look("ram pass");
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 6'h03 : 6'($random(seed));
      eeprom_addr <= a;
      fire(9'h008);
      chk_small(term_addr, a);
      f[2] = par_bad(a);
      look("parity");
    end
    eeprom_fail <= 1'b1;
    eeprom_fail_kind <= 1'b1;
    fire(9'h010);
    chk_small({4'h0, opstat_fail_kind}, 6'h00);
    look("eeprom off");
    auto_init_enable_pin <= 1'b1;
    fire(9'h010);
    f[1] = 1'b1;
    chk_small({4'h0, opstat_fail_kind}, 6'h02);
    look("eeprom fail");
    eeprom_fail_kind <= 1'b0;
    fire(9'h010);
    chk_small({4'h0, opstat_fail_kind}, 6'h01);
    look("eeprom kind");
    // Second master reset with a bad-parity address on the pins
    @(posedge ref_clk);
    rst_n <= 1'b0;
    addr_pins <= 6'h03;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    u = 6'h00;
    f = 6'h00;
    f[2] = par_bad(6'h03);
    chk_small(term_addr, 6'h03);
    chk_small({4'h0, opstat_fail_kind}, 6'h00);
    look("master reset");
    print_verdict;
  end
endmodule
